// ==== design/plcsw_status.sv ====
`timescale 1ns/100ps
// Function
// - bit 5: stop from group member
// - bit 6: stop from lost module link
// - bit 7: stop from lost controller link
// - bit 10: stop commanded by controller
// - aux and sensor pins on bits 0,2,4,6
// - bit 15 heartbeat two seconds each level
// - presence: right bit 0, left bit 1
// - supply word is millivolts, 0 to 35000
// - input bit is pin xor polarity mask
// - leds follow masked input values
// - current word in milliamperes
// - frequency word in hertz
// - temperatures: motor high, module low byte
// - rotation code in motor status bits 1:0
// - bit 2 set in digital output mode
// - fault flags on bits 5 to 15
// - speed bits 13:0 hold actual speed
// - speed limits taken from motor memory
// - reference clamped into the motor range
// - bit 14 when reference above maximum
// - bit 15 when reference below minimum
module plcsw_status
    import plcsw_pkg::*;
#(
    parameter int unsigned HB_HALF_CYCLES = HB_HALF_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // word access port
    input  wire logic                 rd_en,
    input  wire logic                 wr_en,
    input  wire logic [15:0]          addr,
    input  wire logic [15:0]          wr_data,
    output logic      [15:0]          rd_data,
    output logic                      rd_valid,
    // sensor port pins
    input  wire logic                 aux_left_pin,
    input  wire logic                 aux_right_pin,
    input  wire logic                 sig_left_pin,
    input  wire logic                 sig_right_pin,
    input  wire logic                 detect_left_pin,
    input  wire logic                 detect_right_pin,
    output logic      [3:0]           sensor_led,
    // live measurements
    input  wire plcsw_stop_s          stop_cause,
    input  wire logic [15:0]          supply_mv,
    input  wire logic [15:0]          current_ma,
    input  wire logic [15:0]          elec_hz,
    input  wire logic [7:0]           motor_temp_c,
    input  wire logic [7:0]           module_temp_c,
    input  wire plcsw_rot_e           rotation,
    input  wire logic                 digital_mode,
    input  wire plcsw_fault_s         faults,
    input  wire logic [SPEED_W-1:0]   speed_actual,
    // speed reference and limits from motor memory
    input  wire logic [15:0]          speed_ref,
    input  wire logic                 limits_load,
    input  wire logic [SPEED_W-1:0]   mem_speed_min,
    input  wire logic [SPEED_W-1:0]   mem_speed_max,
    output logic      [SPEED_W-1:0]   speed_target
);

    localparam int HB_W = $clog2(HB_HALF_CYCLES + 1);
    localparam logic [HB_W-1:0] HB_LAST = HB_W'(HB_HALF_CYCLES - 1);

    // ==========================================================
    // pin synchronisers
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;

    always_ff @(posedge mclk) begin
        pin_meta <= {detect_left_pin, detect_right_pin, sig_right_pin,
                     sig_left_pin, aux_right_pin, aux_left_pin};
        pin_sync <= pin_meta;
    end

    // ==========================================================
    // polarity mask register
    logic [15:0] polarity;

    always_ff @(posedge mclk) begin
        if (reset) begin
            polarity <= POLARITY_RESET;
        end else if (wr_en && addr == POLARITY_OFF) begin
            polarity <= wr_data;
        end
    end

    // ==========================================================
    // heartbeat
    logic [HB_W-1:0] hb_cnt;
    logic            hb_bit;

    always_ff @(posedge mclk) begin
        if (reset) begin
            hb_cnt <= '0;
            hb_bit <= 1'b1;
        end else if (hb_cnt == HB_LAST) begin
            hb_cnt <= '0;
            hb_bit <= ~hb_bit;
        end else begin
            hb_cnt <= hb_cnt + 1'b1;
        end
    end

    // ==========================================================
    // speed limits and clamping
    logic [SPEED_W-1:0] lim_min;
    logic [SPEED_W-1:0] lim_max;
    logic               ref_above;
    logic               ref_below;

    always_ff @(posedge mclk) begin
        if (reset) begin
            lim_min <= '0;
            lim_max <= '1;
        end else if (limits_load) begin
            lim_min <= mem_speed_min;
            lim_max <= mem_speed_max;
        end
    end

    assign ref_above = speed_ref > {2'b00, lim_max};
    assign ref_below = speed_ref < {2'b00, lim_min};

    always_ff @(posedge mclk) begin
        if (reset) begin
            speed_target <= '0;
        end else if (ref_above) begin
            speed_target <= lim_max;
        end else if (ref_below) begin
            speed_target <= lim_min;
        end else begin
            speed_target <= speed_ref[SPEED_W-1:0];
        end
    end

    // ==========================================================
    // status word assembly
    logic [15:0] next_stop_word;
    logic [15:0] next_sens_word;
    logic [15:0] next_pres_word;
    logic [15:0] next_motor_word;
    logic [15:0] next_speed_word;
    logic [15:0] stop_word;
    logic [15:0] sens_word;
    logic [15:0] pres_word;
    logic [15:0] supply_word;
    logic [15:0] cur_word;
    logic [15:0] hz_word;
    logic [15:0] temp_word;
    logic [15:0] motor_word;
    logic [15:0] speed_word;
    logic [3:0]  pin_in;

    assign pin_in = pin_sync[3:0];

    always_comb begin
        next_stop_word                 = WORD_RESET;
        next_stop_word[STOP_GROUP_BIT] = stop_cause.group_stop;
        next_stop_word[STOP_COMM_BIT]  = stop_cause.comm_link_lost;
        next_stop_word[STOP_PLC_BIT]   = stop_cause.plc_link_lost;
        next_stop_word[STOP_CMD_BIT]   = stop_cause.plc_stop_cmd;

        next_sens_word = WORD_RESET;
        next_sens_word[AUX_LEFT_BIT]  = pin_in[0] ^ polarity[AUX_LEFT_BIT];
        next_sens_word[AUX_RIGHT_BIT] = pin_in[1] ^ polarity[AUX_RIGHT_BIT];
        next_sens_word[SIG_LEFT_BIT]  = pin_in[2] ^ polarity[SIG_LEFT_BIT];
        next_sens_word[SIG_RIGHT_BIT] = pin_in[3] ^ polarity[SIG_RIGHT_BIT];
        next_sens_word[HEARTBEAT_BIT] = hb_bit;

        next_pres_word                 = WORD_RESET;
        next_pres_word[PRES_RIGHT_BIT] = pin_sync[4];
        next_pres_word[PRES_LEFT_BIT]  = pin_sync[5];

        next_motor_word        = WORD_RESET;
        next_motor_word[1:0]   = rotation;
        next_motor_word[DIGITAL_MODE_BIT] = digital_mode;
        next_motor_word[15:5]  = faults;

        next_speed_word                  = WORD_RESET;
        next_speed_word[SPEED_W-1:0]     = speed_actual;
        next_speed_word[SPEED_ABOVE_BIT] = ref_above;
        next_speed_word[SPEED_BELOW_BIT] = ref_below;
    end

    // words refresh every cycle, independent of reads
    always_ff @(posedge mclk) begin
        if (reset) begin
            stop_word   <= WORD_RESET;
            sens_word   <= WORD_RESET;
            pres_word   <= WORD_RESET;
            supply_word <= WORD_RESET;
            cur_word    <= WORD_RESET;
            hz_word     <= WORD_RESET;
            temp_word   <= WORD_RESET;
            motor_word  <= WORD_RESET;
            speed_word  <= WORD_RESET;
        end else begin
            stop_word   <= next_stop_word;
            sens_word   <= next_sens_word;
            pres_word   <= next_pres_word;
            supply_word <= (supply_mv > SUPPLY_MV_MAX) ?
                           SUPPLY_MV_MAX : supply_mv;
            cur_word    <= current_ma;
            hz_word     <= elec_hz;
            temp_word   <= {motor_temp_c, module_temp_c};
            motor_word  <= next_motor_word;
            speed_word  <= next_speed_word;
        end
    end

    // ==========================================================
    // indicator leds
    always_ff @(posedge mclk) begin
        if (reset) begin
            sensor_led <= '0;
        end else begin
            sensor_led <= {next_sens_word[SIG_RIGHT_BIT],
                           next_sens_word[SIG_LEFT_BIT],
                           next_sens_word[AUX_RIGHT_BIT],
                           next_sens_word[AUX_LEFT_BIT]};
        end
    end

    // ==========================================================
    // read port
    logic [15:0] next_rd_data;

    always_comb begin
        if (addr == STOP_CAUSE_OFF) begin
            next_rd_data = stop_word;
        end else if (addr == SUPPLY_MV_OFF) begin
            next_rd_data = supply_word;
        end else if (addr == SENSOR_IN_OFF) begin
            next_rd_data = sens_word;
        end else if (addr == SENSOR_PRES_OFF) begin
            next_rd_data = pres_word;
        end else if (addr == L_CURRENT_OFF) begin
            next_rd_data = cur_word;
        end else if (addr == L_HERTZ_OFF) begin
            next_rd_data = hz_word;
        end else if (addr == L_TEMPS_OFF) begin
            next_rd_data = temp_word;
        end else if (addr == L_FAULT_ROT_OFF) begin
            next_rd_data = motor_word;
        end else if (addr == L_SPEED_OFF) begin
            next_rd_data = speed_word;
        end else if (addr == POLARITY_OFF) begin
            next_rd_data = polarity;
        end else begin
            next_rd_data = WORD_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data  <= WORD_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_stop_bits;
        ##1 stop_word == {5'b0, $past(stop_cause.plc_stop_cmd), 2'b0,
                          $past(stop_cause.plc_link_lost),
                          $past(stop_cause.comm_link_lost),
                          $past(stop_cause.group_stop), 5'b0};
    endproperty
    a_stop_bits: assert property (p_stop_bits)
        else $error("stop cause word mismatch");

    property p_sens_reserved;
        (sens_word & 16'h7faa) == 16'h0000;
    endproperty
    a_sens_reserved: assert property (p_sens_reserved)
        else $error("reserved sensor bits set");

    property p_pin_path;
        ##3 sens_word[AUX_LEFT_BIT] ==
            ($past(aux_left_pin, 3) ^ $past(polarity[AUX_LEFT_BIT], 1));
    endproperty
    a_pin_path: assert property (p_pin_path)
        else $error("left aux input bit wrong");

    property p_hb_toggle;
        (hb_cnt == HB_LAST) |-> ##2 $changed(sens_word[HEARTBEAT_BIT]);
    endproperty
    a_hb_toggle: assert property (p_hb_toggle)
        else $error("heartbeat missed its toggle");

    property p_hb_hold;
        (hb_cnt != HB_LAST) |=> $stable(hb_bit);
    endproperty
    a_hb_hold: assert property (p_hb_hold)
        else $error("heartbeat changed early");

    property p_led;
        ##3 sensor_led[2] ==
            ($past(sig_left_pin, 3) ^ $past(polarity[SIG_LEFT_BIT], 1));
    endproperty
    a_led: assert property (p_led)
        else $error("led does not follow masked input");

    property p_supply;
        supply_word <= SUPPLY_MV_MAX;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply word above range");

    property p_clamp;
        ref_above |=> speed_target == $past(lim_max);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("reference not clamped to maximum");

    property p_speed_flags;
        ##1 speed_word[SPEED_BELOW_BIT:SPEED_ABOVE_BIT] ==
            {$past(ref_below), $past(ref_above)};
    endproperty
    a_speed_flags: assert property (p_speed_flags)
        else $error("speed range flags wrong");

    property p_motor_word;
        ##1 motor_word == {$past(faults), 2'b00, $past(digital_mode),
                           $past(rotation)};
    endproperty
    a_motor_word: assert property (p_motor_word)
        else $error("motor status word wrong");

    property p_read_stable;
        (rd_en && !wr_en && addr == SENSOR_PRES_OFF) |=>
            rd_valid && rd_data == $past(pres_word);
    endproperty
    a_read_stable: assert property (p_read_stable)
        else $error("read of presence word wrong");

    property p_measure_words;
        ##1 cur_word == $past(current_ma) && hz_word == $past(elec_hz) &&
            temp_word == {$past(motor_temp_c), $past(module_temp_c)};
    endproperty
    a_measure_words: assert property (p_measure_words)
        else $error("measurement word mismatch");

    property p_presence;
        ##3 pres_word == {14'h0000, $past(detect_left_pin, 3),
                          $past(detect_right_pin, 3)};
    endproperty
    a_presence: assert property (p_presence)
        else $error("presence word wrong");

    property p_supply_sat;
        (supply_mv > SUPPLY_MV_MAX) |=> supply_word == SUPPLY_MV_MAX;
    endproperty
    a_supply_sat: assert property (p_supply_sat)
        else $error("supply word not saturated");

    property p_clamp_min;
        (ref_below && !ref_above) |=> speed_target == $past(lim_min);
    endproperty
    a_clamp_min: assert property (p_clamp_min)
        else $error("reference not clamped to minimum");

    c_hb: cover property (hb_cnt == HB_LAST && !hb_bit);
    c_above: cover property (ref_above ##1 speed_word[SPEED_ABOVE_BIT]);
    c_below: cover property (ref_below ##1 speed_word[SPEED_BELOW_BIT]);
    c_mask: cover property (wr_en && addr == POLARITY_OFF ##2 rd_en);

endmodule : plcsw_status

// ==== design/plcsw_pkg.sv ====
package plcsw_pkg;
    // ==========================================================
    // word offsets
    localparam logic [15:0] STOP_CAUSE_OFF   = 16'h0013;
    localparam logic [15:0] SUPPLY_MV_OFF    = 16'h0018;
    localparam logic [15:0] SENSOR_IN_OFF    = 16'h0023;
    localparam logic [15:0] SENSOR_PRES_OFF  = 16'h0024;
    localparam logic [15:0] L_CURRENT_OFF    = 16'h0037;
    localparam logic [15:0] L_HERTZ_OFF      = 16'h0038;
    localparam logic [15:0] L_TEMPS_OFF      = 16'h0039;
    localparam logic [15:0] L_FAULT_ROT_OFF  = 16'h003a;
    localparam logic [15:0] L_SPEED_OFF      = 16'h01fb;
    localparam logic [15:0] POLARITY_OFF     = 16'h0040;

    // ==========================================================
    // field positions
    localparam int STOP_GROUP_BIT   = 5;
    localparam int STOP_COMM_BIT    = 6;
    localparam int STOP_PLC_BIT     = 7;
    localparam int STOP_CMD_BIT     = 10;
    localparam int AUX_LEFT_BIT     = 0;
    localparam int AUX_RIGHT_BIT    = 2;
    localparam int SIG_LEFT_BIT     = 4;
    localparam int SIG_RIGHT_BIT    = 6;
    localparam int HEARTBEAT_BIT    = 15;
    localparam int PRES_RIGHT_BIT   = 0;
    localparam int PRES_LEFT_BIT    = 1;
    localparam int DIGITAL_MODE_BIT = 2;
    localparam int SPEED_ABOVE_BIT  = 14;
    localparam int SPEED_BELOW_BIT  = 15;
    localparam int SPEED_W          = 14;

    // ==========================================================
    // reset values and timing
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [15:0] POLARITY_RESET = 16'h0000;
    localparam logic [15:0] SUPPLY_MV_MAX  = 16'h88b8;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned HB_HALF_SEC    = 2;
    localparam int unsigned HB_HALF_CYC    = HB_HALF_SEC * CLK_HZ;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ROT_STOP_BRAKE = 2'b00,
        ROT_CCW        = 2'b01,
        ROT_CW         = 2'b10,
        ROT_STOP_FREE  = 2'b11
    } plcsw_rot_e;

    // order from bit 15 down to bit 5
    typedef struct packed {
        logic motor_unused;
        logic sensor_error;
        logic stalled;
        logic overloaded;
        logic motor_absent;
        logic short_circuit;
        logic over_current;
        logic motor_overheat;
        logic low_voltage;
        logic over_voltage;
        logic board_overheat;
    } plcsw_fault_s;

    typedef struct packed {
        logic plc_stop_cmd;
        logic plc_link_lost;
        logic comm_link_lost;
        logic group_stop;
    } plcsw_stop_s;
endpackage : plcsw_pkg

// ==== sim/plcsw_plc_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// controller side of the word port
module plcsw_plc_model
    import plcsw_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    output logic             rd_en,
    output logic             wr_en,
    output logic [15:0]      addr,
    output logic [15:0]      wr_data
);
    initial begin
        rd_en   = 1'b0;
        wr_en   = 1'b0;
        addr    = 16'hffff;
        wr_data = 16'hffff;
    end

    // ==========================================================
    // one read: pulse, answer seen while rd_valid stands
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge mclk);
        rd_en = 1'b1;
        addr  = a;
        @(negedge mclk);
        rd_en = 1'b0;
        addr  = ~a;
        if (rd_valid === 1'b1) begin
            d = rd_data;
        end else begin
            d = 16'hxxxx;
        end
    endtask : rd

    // ==========================================================
    // one write pulse
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk);
        wr_en   = 1'b1;
        addr    = a;
        wr_data = d;
        @(negedge mclk);
        wr_en   = 1'b0;
        addr    = ~a;
        wr_data = ~d;
    endtask : wr
endmodule : plcsw_plc_model

// ==== sim/test_plcsw_status.sv ====
`timescale 1ns/100ps
module test_plcsw_status
    import plcsw_pkg::*;
;
    logic               mclk = 1'b0;
    logic               reset = 1'b1;
    logic               rd_en;
    logic               wr_en;
    logic [15:0]        addr;
    logic [15:0]        wr_data;
    logic [15:0]        rd_data;
    logic               rd_valid;
    logic [3:0]         pins = 4'h0;
    logic [1:0]         det = 2'h0;
    logic [3:0]         sensor_led;
    plcsw_stop_s        stop_cause = '0;
    logic [15:0]        supply_mv = 16'h0000;
    logic [15:0]        current_ma = 16'h0000;
    logic [15:0]        elec_hz = 16'h0000;
    logic [7:0]         motor_temp_c = 8'h00;
    logic [7:0]         module_temp_c = 8'h00;
    plcsw_rot_e         rotation = ROT_STOP_BRAKE;
    logic               digital_mode = 1'b0;
    plcsw_fault_s       faults = '0;
    logic [SPEED_W-1:0] speed_actual = '0;
    logic [15:0]        speed_ref = 16'h0000;
    logic               limits_load = 1'b0;
    logic [SPEED_W-1:0] mem_speed_min = '0;
    logic [SPEED_W-1:0] mem_speed_max = '0;
    logic [SPEED_W-1:0] speed_target;
    int                 errors = 0;
    int                 cmp_count = 0;

    always #5 mclk = ~mclk;

    plcsw_status #(.HB_HALF_CYCLES(8)) u_plcsw_status (
        .mclk(mclk), .reset(reset), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .aux_left_pin(pins[0]),
        .aux_right_pin(pins[1]), .sig_left_pin(pins[2]),
        .sig_right_pin(pins[3]), .detect_left_pin(det[1]),
        .detect_right_pin(det[0]), .sensor_led(sensor_led),
        .stop_cause(stop_cause), .supply_mv(supply_mv),
        .current_ma(current_ma), .elec_hz(elec_hz),
        .motor_temp_c(motor_temp_c), .module_temp_c(module_temp_c),
        .rotation(rotation), .digital_mode(digital_mode),
        .faults(faults), .speed_actual(speed_actual),
        .speed_ref(speed_ref), .limits_load(limits_load),
        .mem_speed_min(mem_speed_min), .mem_speed_max(mem_speed_max),
        .speed_target(speed_target)
    );

    plcsw_plc_model u_plcsw_plc_model (
        .mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data)
    );

    // ==========================================================
    // checking and ending
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic rdchk(input string what, input logic [15:0] a,
                         input logic [15:0] exp);
        logic [15:0] d;
        u_plcsw_plc_model.rd(a, d);
        chk(what, exp, d);
    endtask : rdchk

    // ==========================================================
    // scenarios
    task automatic t_stop;
        logic [15:0] e;
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk);
            stop_cause = plcsw_stop_s'(4'(i));
            e = 16'h0000;
            e[STOP_GROUP_BIT] = i[0];
            e[STOP_COMM_BIT]  = i[1];
            e[STOP_PLC_BIT]   = i[2];
            e[STOP_CMD_BIT]   = i[3];
            rdchk("stop_word", STOP_CAUSE_OFF, e);
        end
    endtask : t_stop

    task automatic t_sensor(input logic [15:0] m);
        logic [15:0] d;
        logic [3:0]  v;
        u_plcsw_plc_model.wr(POLARITY_OFF, m);
        rdchk("mask_readback", POLARITY_OFF, m);
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk);
            pins = 4'(i);
            repeat (4) @(negedge mclk);
            v = 4'(i) ^ {m[6], m[4], m[2], m[0]};
            u_plcsw_plc_model.rd(SENSOR_IN_OFF, d);
            chk("sensor_word", {9'h000, v[3], 1'b0, v[2], 1'b0, v[1],
                1'b0, v[0]}, d & 16'h7fff);
            chk("sensor_led", {12'h000, v}, {12'h000, sensor_led});
        end
    endtask : t_sensor

    task automatic t_heartbeat;
        logic [15:0] d;
        logic        last;
        int          n;
        int          gap;
        u_plcsw_plc_model.rd(SENSOR_IN_OFF, d);
        last = d[HEARTBEAT_BIT];
        n = 0;
        gap = 0;
        for (int i = 0; i < 40; i++) begin
            u_plcsw_plc_model.rd(SENSOR_IN_OFF, d);
            gap++;
            if (d[HEARTBEAT_BIT] !== last) begin
                if (n > 0) chk("heartbeat_gap", 16'h0004, 16'(gap));
                n++;
                gap = 0;
                last = d[HEARTBEAT_BIT];
            end
        end
        chk("heartbeat_edges", 16'h0001, 16'(n >= 3));
    endtask : t_heartbeat

    task automatic t_presence;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            det = 2'(i);
            repeat (4) @(negedge mclk);
            rdchk("presence", SENSOR_PRES_OFF, 16'(i));
        end
    endtask : t_presence

    task automatic t_measure;
        @(negedge mclk);
        supply_mv = 16'h5bcc;
        current_ma = 16'h076c;
        elec_hz = 16'h012c;
        motor_temp_c = 8'h5a;
        module_temp_c = 8'h21;
        faults = plcsw_fault_s'(11'h5a5);
        rdchk("supply", SUPPLY_MV_OFF, 16'h5bcc);
        rdchk("current", L_CURRENT_OFF, 16'h076c);
        rdchk("hertz", L_HERTZ_OFF, 16'h012c);
        rdchk("temps", L_TEMPS_OFF, 16'h5a21);
        @(negedge mclk);
        supply_mv = 16'h9c40;
        rdchk("supply_sat", SUPPLY_MV_OFF, SUPPLY_MV_MAX);
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            rotation = plcsw_rot_e'(i[1:0]);
            digital_mode = i[2];
            rdchk("motor_status", L_FAULT_ROT_OFF, {11'h5a5, 2'b00, i[2],
                  i[1:0]});
        end
    endtask : t_measure

    task automatic speed_case(input logic [15:0] r,
                              input logic [15:0] w);
        @(negedge mclk);
        speed_ref = r;
        speed_actual = w[SPEED_W-1:0];
        rdchk("speed_word", L_SPEED_OFF, w);
        chk("speed_target", {2'b00, w[SPEED_W-1:0]},
            {2'b00, speed_target});
    endtask : speed_case

    task automatic t_speed;
        @(negedge mclk);
        limits_load = 1'b1;
        mem_speed_min = 14'h0064;
        mem_speed_max = 14'h053c;
        @(negedge mclk);
        limits_load = 1'b0;
        speed_case(16'h07d0, 16'h453c);
        speed_case(16'h0032, 16'h8064);
        speed_case(16'h01f4, 16'h01f4);
        speed_case(16'h053c, 16'h053c);
    endtask : t_speed

    task automatic t_refuse;
        @(negedge mclk);
        stop_cause = '0;
        u_plcsw_plc_model.wr(STOP_CAUSE_OFF, 16'hffff);
        rdchk("stop_no_write", STOP_CAUSE_OFF, 16'h0000);
        rdchk("unmapped", 16'h0100, 16'h0000);
        rdchk("reread_1", L_CURRENT_OFF, 16'h076c);
        rdchk("reread_2", L_CURRENT_OFF, 16'h076c);
    endtask : t_refuse

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        rdchk("stop_reset", STOP_CAUSE_OFF, 16'h0000);
        t_stop();
        t_sensor(16'h0000);
        t_sensor(16'hffff);
        t_heartbeat();
        t_presence();
        t_measure();
        t_speed();
        t_refuse();
        end_of_test();
    end

    initial begin
        #300000;
        errors++;
        end_of_test();
    end
endmodule : test_plcsw_status
